/* cbrs_align.sv */
// Purpose: Alignment check and little-endian byte lanes for a data access.
// Assumes: Purely combinational.
// Notes: Lane 0 is the byte at the lowest address of the word.
module cbrs_align (
  input wire logic [1:0] addr_lo_i,              // Low address bits
  input wire cbrs_pkg::cbrs_size_type size_i,    // Access size
  output logic misalign_o,                       // Access breaks alignment
  output logic [3:0] lanes_o                     // Byte lanes touched
);
  import cbrs_pkg::*;

  always_comb begin
    misalign_o = 1'b0;
    lanes_o = 4'h0;
    case (size_i)
      size_byte: lanes_o = 4'(4'h1 << addr_lo_i);
      size_half: begin
        misalign_o = addr_lo_i[0];
        lanes_o = addr_lo_i[1] ? 4'hc : 4'h3;
      end
      size_word: begin
        misalign_o = addr_lo_i != 2'h0;
        lanes_o = 4'hf;
      end
      default: misalign_o = 1'b1;
    endcase
    if (misalign_o) begin
      lanes_o = 4'h0;
    end
  end

endmodule

/* cbrs_core_state.sv */
// Purpose: Programmer-visible state of the core: banked registers, status words, program counter.
// Assumes: One operation per cycle from the execute stage; inputs synchronous to mclk_i.
// Notes: Read ports are combinational muxes of flip-flops.
// What this block does
// [RULE1] Two instruction states; switching keeps mode and all register values.
// [RULE2] Wide state fetches words on word boundaries, compact halfwords on halfword.
// [RULE3] Branch-exchange selects the state at the branch target.
// [RULE4] Exceptions run in wide state; return restores the compact state.
// [RULE5] Addresses are 32 bits into one flat space for code and data.
// [RULE6] Little-endian: lowest byte at lowest address, word address is that byte.
// [RULE7] Byte, halfword and word data; words 4-aligned, halfwords 2-aligned.
// [RULE8] Seven modes, changed by software or by exceptions.
// [RULE9] 31 general registers and six status words; visibility follows state and mode.
// [RULE10] Wide state sees registers 0 to 15 and the current status word.
// [RULE11] Branch-with-link and exceptions write the return address into the link register.
// [RULE12] Program counter low bits read zero: two in wide, one in compact.
// [RULE13] Fast interrupt mode banks registers 8 to 14.
// [RULE14] Supervisor, abort, interrupt and undefined modes bank registers 13 and 14.
// [RULE15] Compact state shares registers 0-7, status words, SP 13, LR 14, PC 15.
// [RULE16] Compact state reaches registers 8 to 12 only through special instructions.
// [RULE17] One current and five saved status words, one per exception mode.
// [RULE18] Flags N Z C V; all wide instructions conditional, compact only branches.
// [RULE19] Low eight bits are control bits; only privileged software changes them.
// [RULE20] State bit reads 1 compact, 0 wide; software writes to it are kept out.
// [RULE21] Interrupt mask bits at 1 block normal and fast interrupts.
// [RULE22] Mode codes per table; unlisted codes are refused. Saved word writes here keep any code, and exception return loads it.
// [RULE23] Abort mode uses code 10111.
// [RULE24] User and system share the unbanked set and have no saved status word.
// [RULE25] Exception entry saves status, sets new mode and both mask bits.
module cbrs_core_state (
  input wire logic mclk_i,                             // Core clock
  input wire logic srst_i,                             // Synchronous reset
  input wire cbrs_pkg::cbrs_op_type op_i,              // Control operation this cycle
  input wire logic [31:0] op_data_i,                   // Target address or status value
  input wire cbrs_pkg::cbrs_exc_type exc_i,            // Exception entry details
  input wire cbrs_pkg::cbrs_wr_type wr_i,              // Register write port
  input wire logic hi_access_i,                        // Instruction may touch upper registers
  input wire logic [3:0] rd_a_sel_i,                   // Read port A register number
  input wire logic [3:0] rd_b_sel_i,                   // Read port B register number
  output logic [31:0] rd_a_o,                          // Read port A data
  output logic [31:0] rd_b_o,                          // Read port B data
  input wire logic [3:0] flags_i,                      // New N Z C V for flag updates
  input wire logic [3:0] cond_i,                       // Condition field
  input wire logic cond_branch_i,                      // Compact conditional branch
  output logic cond_pass_o,                            // Instruction may execute
  output logic [31:0] current_status_word_o,           // Current status word
  output logic [31:0] saved_status_word_o,             // Saved word of current mode
  output logic [31:0] fetch_addr_o,                    // Next fetch address
  output logic compact_o,                              // Compact state active
  output logic [4:0] mode_o,                           // Current mode field
  output logic privileged_o,                           // Current mode privileged
  input wire logic irq_req_i,                          // Normal interrupt request
  input wire logic fiq_req_i,                          // Fast interrupt request
  output logic irq_take_o,                             // Normal interrupt accepted
  output logic fiq_take_o,                             // Fast interrupt accepted
  input wire logic [31:0] data_addr_i,                 // Data access address
  input wire cbrs_pkg::cbrs_size_type data_size_i,     // Data access size
  output logic data_misalign_o,                        // Data access misaligned
  output logic [3:0] data_lanes_o                      // Byte lanes of the access
);
  import cbrs_pkg::*;

  logic [31:0] gp_q [CBRS_NUM_PHYS];
  logic [31:0] saved_q [CBRS_NUM_SAVED];
  logic [31:0] pc_q, pc_d;
  logic [31:0] psr_q, psr_d;
  cbrs_bank_type cur_bank, exc_bank, new_bank;
  logic cur_valid, cur_priv, cur_has_saved;
  logic exc_valid, exc_priv, exc_has_saved;
  logic new_valid, new_priv, new_has_saved;
  logic [2:0] cur_saved_idx, exc_saved_idx, new_saved_idx;
  logic compact;
  logic [31:0] ins_len;
  logic link_we;
  logic [4:0] link_phys;
  logic [31:0] link_val;
  logic wr_ok;
  logic [4:0] wr_phys;
  logic pc_by_wr;

  cbrs_mode_dec u_cur_dec (.mode_i(psr_q[CBRS_PSR_MODE_LSB +: 5]), .bank_o(cur_bank), .valid_o(cur_valid),
    .priv_o(cur_priv), .has_saved_o(cur_has_saved), .saved_idx_o(cur_saved_idx));

  cbrs_mode_dec u_exc_dec (.mode_i(exc_i.mode), .bank_o(exc_bank), .valid_o(exc_valid),
    .priv_o(exc_priv), .has_saved_o(exc_has_saved), .saved_idx_o(exc_saved_idx));

  cbrs_mode_dec u_new_dec (.mode_i(op_data_i[CBRS_PSR_MODE_LSB +: 5]), .bank_o(new_bank), .valid_o(new_valid),
    .priv_o(new_priv), .has_saved_o(new_has_saved), .saved_idx_o(new_saved_idx));

  cbrs_align u_align (.addr_lo_i(data_addr_i[1:0]), .size_i(data_size_i), .misalign_o(data_misalign_o),
    .lanes_o(data_lanes_o)); // RULE6 RULE7

  // Map a visible register number to its physical slot for a bank
  function automatic logic [4:0] phys_idx(input logic [3:0] sel, input cbrs_bank_type bank);
    logic [4:0] idx;
    idx = {1'b0, sel};
    if (bank == bank_fiq && sel >= 4'h8 && sel <= 4'he) begin
      idx = 5'(CBRS_FIQ_BASE + {1'b0, sel} - 5'h08); // RULE13
    end else if (sel == 4'hd || sel == 4'he) begin
      case (bank) // RULE14
        bank_svc: idx = 5'(CBRS_SVC_BASE + {1'b0, sel} - 5'h0d);
        bank_abt: idx = 5'(CBRS_ABT_BASE + {1'b0, sel} - 5'h0d);
        bank_irq: idx = 5'(CBRS_IRQ_BASE + {1'b0, sel} - 5'h0d);
        bank_und: idx = 5'(CBRS_UND_BASE + {1'b0, sel} - 5'h0d);
        default: idx = {1'b0, sel}; // RULE24
      endcase
    end
    return idx;
  endfunction

  function automatic logic [31:0] align_pc(input logic [31:0] v, input logic t);
    return t ? {v[31:1], 1'b0} : {v[31:2], 2'b00}; // RULE12
  endfunction

  function automatic logic cond_eval(input logic [3:0] c, input logic [3:0] f);
    logic n, z, cy, v, r;
    n = f[3];
    z = f[2];
    cy = f[1];
    v = f[0];
    case (c)
      4'h0: r = z;
      4'h1: r = !z;
      4'h2: r = cy;
      4'h3: r = !cy;
      4'h4: r = n;
      4'h5: r = !n;
      4'h6: r = v;
      4'h7: r = !v;
      4'h8: r = cy && !z;
      4'h9: r = !cy || z;
      4'ha: r = n == v;
      4'hb: r = n != v;
      4'hc: r = !z && (n == v);
      4'hd: r = z || (n != v);
      4'he: r = 1'b1;
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  // Compact state keeps registers 8..12 out of reach unless the instruction allows it
  function automatic logic sel_allowed(input logic [3:0] sel, input logic t, input logic hi);
    return !t || sel < 4'h8 || sel > 4'hc || hi; // RULE15 RULE16
  endfunction

  function automatic logic [31:0] read_reg(input logic [3:0] sel);
    logic [31:0] r;
    r = 32'h0;
    if (sel == 4'hf) begin
      r = pc_q; // RULE10
    end else if (sel_allowed(sel, compact, hi_access_i)) begin
      r = gp_q[phys_idx(sel, cur_bank)]; // RULE9
    end
    return r;
  endfunction

  assign compact = psr_q[CBRS_PSR_T];
  assign ins_len = compact ? CBRS_COMPACT_LEN : CBRS_WIDE_LEN;
  // A process, so the reads follow the register contents as well as the selects
  always_comb begin
    rd_a_o = read_reg(rd_a_sel_i);
    rd_b_o = read_reg(rd_b_sel_i);
  end
  assign current_status_word_o = psr_q;
  assign saved_status_word_o = cur_has_saved ? saved_q[cur_saved_idx] : 32'h0; // RULE24
  assign fetch_addr_o = align_pc(pc_q, compact); // RULE2 RULE5
  assign compact_o = compact; // RULE20
  assign mode_o = psr_q[CBRS_PSR_MODE_LSB +: 5];
  assign privileged_o = cur_priv;
  assign irq_take_o = irq_req_i && !psr_q[CBRS_PSR_I]; // RULE21
  assign fiq_take_o = fiq_req_i && !psr_q[CBRS_PSR_F]; // RULE21
  // Wide instructions always test the flags; compact ones only as conditional branches
  assign cond_pass_o = (!compact || cond_branch_i) ? cond_eval(cond_i, psr_q[31:28]) : 1'b1; // RULE18

  assign wr_ok = wr_i.en && wr_i.sel != 4'hf && sel_allowed(wr_i.sel, compact, hi_access_i);
  assign wr_phys = phys_idx(wr_i.sel, cur_bank);
  assign pc_by_wr = wr_i.en && wr_i.sel == 4'hf;

  // Return address written by link and exception entry
  always_comb begin
    link_we = 1'b0;
    link_phys = 5'h0e;
    link_val = 32'(pc_q + ins_len);
    if (op_i == op_branch_link) begin
      link_we = 1'b1; // RULE11
      link_phys = phys_idx(4'he, cur_bank);
    end else if (op_i == op_exc_entry && exc_valid) begin
      link_we = 1'b1; // RULE11
      link_phys = phys_idx(4'he, exc_bank);
      link_val = 32'(pc_q + {28'h0, exc_i.link_offset});
    end
  end

  // General registers; the link write outranks the port write to the same slot
  generate
    for (genvar gi = 0; gi < CBRS_NUM_PHYS; gi++) begin : g_gp
      if (gi == int'(CBRS_PC_SLOT)) begin : g_pc_slot
        always_ff @(posedge mclk_i) begin
          gp_q[gi] <= CBRS_GP_RESET;
        end
      end else begin : g_reg
        always_ff @(posedge mclk_i) begin
          if (srst_i) begin
            gp_q[gi] <= CBRS_GP_RESET;
          end else if (link_we && link_phys == 5'(gi)) begin
            gp_q[gi] <= link_val; // RULE11
          end else if (wr_ok && wr_phys == 5'(gi)) begin
            gp_q[gi] <= wr_i.data; // RULE15
          end
        end
      end
    end
  endgenerate

  // Program counter
  always_comb begin
    pc_d = pc_q;
    case (op_i)
      op_advance: pc_d = 32'(pc_q + ins_len); // RULE2
      op_branch, op_branch_link: pc_d = align_pc(op_data_i, compact);
      op_branch_exchange: pc_d = align_pc(op_data_i, op_data_i[0]); // RULE3
      op_exc_entry: begin
        if (exc_valid) begin
          pc_d = align_pc(exc_i.vector, 1'b0); // RULE4
        end
      end
      op_exc_return: begin
        if (cur_has_saved) begin
          pc_d = align_pc(op_data_i, saved_q[cur_saved_idx][CBRS_PSR_T]); // RULE4
        end
      end
      default: begin
        if (pc_by_wr) begin
          pc_d = align_pc(wr_i.data, compact); // RULE12
        end
      end
    endcase
  end
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      pc_q <= CBRS_PC_RESET;
    end else begin
      pc_q <= pc_d;
    end
  end

  // Current status word
  always_comb begin
    psr_d = psr_q;
    case (op_i)
      op_flags_write: psr_d[31:28] = flags_i; // RULE18
      op_branch_exchange: psr_d[CBRS_PSR_T] = op_data_i[0]; // RULE1 RULE3
      op_status_write: begin
        psr_d[31:28] = op_data_i[31:28];
        if (cur_priv) begin
          psr_d[CBRS_PSR_I] = op_data_i[CBRS_PSR_I]; // RULE19
          psr_d[CBRS_PSR_F] = op_data_i[CBRS_PSR_F];
          if (new_valid) begin
            psr_d[CBRS_PSR_MODE_LSB +: 5] = op_data_i[CBRS_PSR_MODE_LSB +: 5]; // RULE8 RULE22
          end
        end
      end
      op_exc_entry: begin
        if (exc_valid) begin
          psr_d[CBRS_PSR_MODE_LSB +: 5] = exc_i.mode; // RULE8 RULE25
          psr_d[CBRS_PSR_I] = 1'b1; // RULE25
          psr_d[CBRS_PSR_F] = 1'b1;
          psr_d[CBRS_PSR_T] = 1'b0; // RULE4
        end
      end
      op_exc_return: begin
        if (cur_has_saved) begin
          psr_d = saved_q[cur_saved_idx] & CBRS_PSR_USED; // RULE4
        end
      end
      default: psr_d = psr_q;
    endcase
  end
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      psr_q <= CBRS_PSR_RESET;
    end else begin
      psr_q <= psr_d;
    end
  end

  // Saved status words, one per exception mode
  generate
    for (genvar si = 0; si < CBRS_NUM_SAVED; si++) begin : g_saved
      always_ff @(posedge mclk_i) begin
        if (srst_i) begin
          saved_q[si] <= CBRS_PSR_RESET;
        end else if (op_i == op_exc_entry && exc_valid && exc_has_saved && exc_saved_idx == 3'(si)) begin
          saved_q[si] <= psr_q; // RULE17 RULE25
        end else if (op_i == op_saved_write && cur_has_saved && cur_saved_idx == 3'(si)) begin
          saved_q[si] <= op_data_i & CBRS_PSR_USED; // RULE17 RULE24
        end
      end
    end
  endgenerate

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (srst_i);
  sequence s_bx_issue;
    op_i == op_branch_exchange;
  endsequence
  sequence s_exc_issue;
    op_i == op_exc_entry && exc_valid;
  endsequence

  property p_state_keeps_mode;
    s_bx_issue |=> $stable(psr_q[CBRS_PSR_MODE_LSB +: 5]) && $stable(psr_q[31:28]);
  endproperty
  a_state_keeps_mode: assert property (p_state_keeps_mode) else $error("mode changed on state switch"); // RULE1
  property p_bx_selects_state;
    s_bx_issue |=> compact_o == $past(op_data_i[0]) && fetch_addr_o[0] == 1'b0;
  endproperty
  a_bx_selects_state: assert property (p_bx_selects_state) else $error("state not taken from target"); // RULE3
  property p_fetch_align;
    compact_o ? fetch_addr_o[0] == 1'b0 : fetch_addr_o[1:0] == 2'b00;
  endproperty
  a_fetch_align: assert property (p_fetch_align) else $error("fetch address misaligned"); // RULE12
  property p_advance_len;
    op_i == op_advance |=> pc_q == 32'($past(pc_q) + ($past(compact) ? 32'h2 : 32'h4));
  endproperty
  a_advance_len: assert property (p_advance_len) else $error("program counter step wrong"); // RULE2
  property p_exc_entry;
    s_exc_issue |=> !compact_o && psr_q[CBRS_PSR_I] && psr_q[CBRS_PSR_F]
      && mode_o == $past(exc_i.mode) && saved_status_word_o == $past(psr_q);
  endproperty
  a_exc_entry: assert property (p_exc_entry) else $error("exception entry state wrong"); // RULE25
  // The handler spends one idle cycle before it returns
  property p_exc_round_trip;
    (s_exc_issue and compact_o) ##1 (op_i == op_none) ##1 (op_i == op_exc_return) |=> compact_o;
  endproperty
  a_exc_round_trip: assert property (p_exc_round_trip) else $error("compact state not restored"); // RULE4
  property p_link_written;
    op_i == op_branch_link |=> gp_q[phys_idx(4'he, cur_bank)] == 32'($past(pc_q) + $past(ins_len));
  endproperty
  a_link_written: assert property (p_link_written) else $error("link register not written"); // RULE11
  property p_user_control;
    op_i == op_status_write && !privileged_o |=> $stable(psr_q[7:0]);
  endproperty
  a_user_control: assert property (p_user_control) else $error("user changed control bits"); // RULE19
  property p_irq_mask;
    psr_q[CBRS_PSR_I] |-> !irq_take_o;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("masked interrupt accepted"); // RULE21
  property p_no_saved_unbanked;
    op_i == op_saved_write && !cur_has_saved |=> saved_q[1] == $past(saved_q[1]) && saved_q[0] == $past(saved_q[0]);
  endproperty
  a_no_saved_unbanked: assert property (p_no_saved_unbanked) else $error("saved word written without one"); // RULE24
  property p_mode_valid;
    op_i == op_status_write && !new_valid |=> $stable(mode_o);
  endproperty
  a_mode_valid: assert property (p_mode_valid) else $error("unlisted mode accepted"); // RULE22

endmodule

/* cbrs_mode_dec.sv */
// Purpose: Decode a five-bit mode code into its bank and privileges.
// Assumes: Purely combinational.
// Notes: Unlisted codes report invalid and fall back to the shared bank.
module cbrs_mode_dec (
  input wire logic [4:0] mode_i,                 // Mode field
  output cbrs_pkg::cbrs_bank_type bank_o,        // Register bank in use
  output logic valid_o,                          // Code is one of the seven
  output logic priv_o,                           // Privileged mode
  output logic has_saved_o,                      // Owns a saved status word
  output logic [2:0] saved_idx_o                 // Which saved status word
);
  import cbrs_pkg::*;

  always_comb begin
    bank_o = bank_usr;
    valid_o = 1'b1;
    priv_o = 1'b1;
    has_saved_o = 1'b1;
    saved_idx_o = 3'h0;
    case (mode_i)
      CBRS_MODE_USR: begin
        priv_o = 1'b0;
        has_saved_o = 1'b0;
      end
      CBRS_MODE_SYS: has_saved_o = 1'b0;
      CBRS_MODE_FIQ: bank_o = bank_fiq;
      CBRS_MODE_SVC: begin
        bank_o = bank_svc;
        saved_idx_o = 3'h1;
      end
      CBRS_MODE_ABT: begin
        bank_o = bank_abt;
        saved_idx_o = 3'h2;
      end
      CBRS_MODE_IRQ: begin
        bank_o = bank_irq;
        saved_idx_o = 3'h3;
      end
      CBRS_MODE_UND: begin
        bank_o = bank_und;
        saved_idx_o = 3'h4;
      end
      default: begin
        valid_o = 1'b0;
        priv_o = 1'b0;
        has_saved_o = 1'b0;
      end
    endcase
  end

endmodule

/* cbrs_pkg.sv */
// Purpose: Shared constants and types for the banked core register state.
// Assumes: One clock, synchronous active-high reset.
// Notes: Status word field positions and mode codes live here.
package cbrs_pkg;

  localparam int CBRS_NUM_PHYS = 31;
  localparam int CBRS_NUM_SAVED = 5;

  // Physical slots of banked copies; slots 0..14 are the shared set, 15 is the program counter
  localparam logic [4:0] CBRS_PC_SLOT = 5'h0f;
  localparam logic [4:0] CBRS_FIQ_BASE = 5'h10;
  localparam logic [4:0] CBRS_SVC_BASE = 5'h17;
  localparam logic [4:0] CBRS_ABT_BASE = 5'h19;
  localparam logic [4:0] CBRS_IRQ_BASE = 5'h1b;
  localparam logic [4:0] CBRS_UND_BASE = 5'h1d;

  localparam logic [4:0] CBRS_MODE_USR = 5'h10;
  localparam logic [4:0] CBRS_MODE_FIQ = 5'h11;
  localparam logic [4:0] CBRS_MODE_IRQ = 5'h12;
  localparam logic [4:0] CBRS_MODE_SVC = 5'h13;
  localparam logic [4:0] CBRS_MODE_ABT = 5'h17;
  localparam logic [4:0] CBRS_MODE_UND = 5'h1b;
  localparam logic [4:0] CBRS_MODE_SYS = 5'h1f;

  localparam int CBRS_PSR_N = 31;
  localparam int CBRS_PSR_Z = 30;
  localparam int CBRS_PSR_C = 29;
  localparam int CBRS_PSR_V = 28;
  localparam int CBRS_PSR_I = 7;
  localparam int CBRS_PSR_F = 6;
  localparam int CBRS_PSR_T = 5;
  localparam int CBRS_PSR_MODE_LSB = 0;
  localparam logic [31:0] CBRS_PSR_USED = 32'hf00000ff;
  localparam logic [31:0] CBRS_PSR_RESET = 32'h000000d3;
  localparam logic [31:0] CBRS_PC_RESET = 32'h00000000;
  localparam logic [31:0] CBRS_GP_RESET = 32'h00000000;

  localparam logic [31:0] CBRS_WIDE_LEN = 32'h00000004;
  localparam logic [31:0] CBRS_COMPACT_LEN = 32'h00000002;

  typedef enum logic [2:0] {
    bank_usr, bank_fiq, bank_irq, bank_svc, bank_abt, bank_und
  } cbrs_bank_type;

  typedef enum logic [3:0] {
    op_none, op_advance, op_branch, op_branch_link, op_branch_exchange,
    op_exc_entry, op_exc_return, op_status_write, op_saved_write, op_flags_write
  } cbrs_op_type;

  typedef enum logic [1:0] {
    size_byte, size_half, size_word
  } cbrs_size_type;

  typedef struct packed {
    logic en;
    logic [3:0] sel;
    logic [31:0] data;
  } cbrs_wr_type;

  typedef struct packed {
    logic [4:0] mode;
    logic [31:0] vector;
    logic [3:0] link_offset;
  } cbrs_exc_type;

endpackage

/* cpu_banked_register_state_tb_top.sv */
// Purpose: Self-checking bench for the banked core register state.
// Assumes: Contract of one operation per cycle, results visible one cycle later.
// Notes: Alignment cases run from a table; state changes are hand-written after it.
module cpu_banked_register_state_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import cbrs_pkg::*;

  typedef struct packed {
    logic [31:0] addr;
    cbrs_size_type size;
    logic mis;
    logic [3:0] lanes;
  } cbrs_row_type;

  logic mclk_i = 1'b0;
  logic srst_i = 1'b1;
  cbrs_op_type op_i = op_none;
  logic [31:0] op_data_i = 32'h0;
  cbrs_exc_type exc_i = '0;
  cbrs_wr_type wr_i = '0;
  logic hi_access_i = 1'b0;
  logic [3:0] rd_a_sel_i = 4'h0;
  logic [31:0] rd_a_o;
  logic [31:0] rd_b_o;
  logic [3:0] flags_i = 4'h0;
  logic [3:0] cond_i = 4'he;
  logic cond_branch_i = 1'b0;
  logic pass_o;
  logic [31:0] st_o;
  logic [31:0] sv_o;
  logic [31:0] pc_o;
  logic compact_o;
  logic [4:0] mode_o;
  logic priv_o;
  logic irq_req_i = 1'b0;
  logic fiq_req_i = 1'b0;
  logic irq_take_o;
  logic fiq_take_o;
  logic [31:0] data_addr_i = 32'h0;
  cbrs_size_type data_size_i = size_byte;
  logic mis_o;
  logic [3:0] lanes_o;
  int failures = 0;
  int n_tests = 0;
  cbrs_row_type rows [8] = '{
    '{32'h00000000, size_byte, 1'b0, 4'h1}, '{32'h00000003, size_byte, 1'b0, 4'h8},
    '{32'h00000002, size_half, 1'b0, 4'hc}, '{32'h00000001, size_half, 1'b1, 4'h0},
    '{32'h00000004, size_word, 1'b0, 4'hf}, '{32'h00000002, size_word, 1'b1, 4'h0},
    '{32'hfffffffc, size_word, 1'b0, 4'hf}, '{32'h00000003, size_half, 1'b1, 4'h0}};

  always #50 mclk_i = ~mclk_i;

  cbrs_core_state i_dut (
    .mclk_i(mclk_i), .srst_i(srst_i), .op_i(op_i), .op_data_i(op_data_i), .exc_i(exc_i),
    .wr_i(wr_i), .hi_access_i(hi_access_i), .rd_a_sel_i(rd_a_sel_i), .rd_b_sel_i(4'h0),
    .rd_a_o(rd_a_o), .rd_b_o(rd_b_o), .flags_i(flags_i), .cond_i(cond_i), .cond_branch_i(cond_branch_i),
    .cond_pass_o(pass_o), .current_status_word_o(st_o), .saved_status_word_o(sv_o),
    .fetch_addr_o(pc_o), .compact_o(compact_o), .mode_o(mode_o), .privileged_o(priv_o),
    .irq_req_i(irq_req_i), .fiq_req_i(fiq_req_i), .irq_take_o(irq_take_o), .fiq_take_o(fiq_take_o),
    .data_addr_i(data_addr_i), .data_size_i(data_size_i), .data_misalign_o(mis_o),
    .data_lanes_o(lanes_o)
  );

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task run_op(input cbrs_op_type o, input logic [31:0] d);
    @(posedge mclk_i);
    op_i <= o;
    op_data_i <= d;
    @(posedge mclk_i);
    op_i <= op_none;
    #1;
  endtask

  task do_wr(input logic [3:0] sel, input logic [31:0] d);
    @(posedge mclk_i);
    wr_i <= '{1'b1, sel, d};
    @(posedge mclk_i);
    wr_i.en <= 1'b0;
    #1;
  endtask

  task test_done;
    $display("Counts: %0d comparisons, %0d mismatches", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge mclk_i);
    #1;
    chk(st_o, CBRS_PSR_RESET);
    chk(pc_o, CBRS_PC_RESET);
    chk({27'h0, mode_o}, {27'h0, CBRS_MODE_SVC});
    @(posedge mclk_i);
    srst_i <= 1'b0;
    $display("Test reset done");
    foreach (rows[i]) begin
      @(posedge mclk_i);
      data_addr_i <= rows[i].addr;
      data_size_i <= rows[i].size;
      #1;
      chk({31'h0, mis_o}, {31'h0, rows[i].mis});
      if (!rows[i].mis) chk({28'h0, lanes_o}, {28'h0, rows[i].lanes});
    end
    $display("Test alignment table done");
    // Branch-exchange into the compact state at an odd target
    run_op(op_branch_exchange, 32'h00000101);
    chk({31'h0, compact_o}, 32'h1);
    chk(pc_o, 32'h00000100);
    chk(st_o, 32'h000000f3);
    // Link holds next compact instruction address
    rd_a_sel_i <= 4'he;
    run_op(op_branch_link, 32'h00000200);
    chk(rd_a_o, 32'h00000102);
    chk(pc_o, 32'h00000200);
    exc_i <= '{CBRS_MODE_IRQ, 32'h00000018, 4'h4};
    run_op(op_exc_entry, 32'h0);
    chk(st_o, 32'h000000d2);
    chk(sv_o, 32'h000000f3);
    chk(pc_o, 32'h00000018);
    chk(rd_a_o, 32'h00000204);
    run_op(op_exc_return, 32'h00000200);
    chk(st_o, 32'h000000f3);
    chk(pc_o, 32'h00000200);
    chk(rd_a_o, 32'h00000102);
    $display("Test state and exception done");
    // Drop to user mode with masks clear; state bit must survive
    irq_req_i <= 1'b1;
    fiq_req_i <= 1'b1;
    run_op(op_status_write, 32'h00000010);
    chk(st_o, 32'h00000030);
    chk({31'h0, priv_o}, 32'h0);
    chk({30'h0, irq_take_o, fiq_take_o}, 32'h3);
    chk(sv_o, 32'h0);
    run_op(op_status_write, 32'hf00000d3);
    chk(st_o, 32'hf0000030);
    // Upper registers in compact state need the special access
    do_wr(4'h9, 32'h00000055);
    rd_a_sel_i <= 4'h9;
    hi_access_i <= 1'b1;
    #1;
    chk(rd_a_o, 32'h0);
    do_wr(4'h9, 32'h00000066);
    chk(rd_a_o, 32'h00000066);
    @(posedge mclk_i);
    hi_access_i <= 1'b0;
    #1;
    chk(rd_a_o, 32'h0);
    $display("Test privilege and upper registers done");
    // Low registers shared; compact step; flags gate only compact branches
    do_wr(4'h0, 32'h00000077);
    chk(rd_b_o, 32'h00000077);
    run_op(op_advance, 32'h0);
    chk(pc_o, 32'h00000202);
    flags_i <= 4'h4;
    run_op(op_flags_write, 32'h0);
    chk(st_o, 32'h40000030);
    cond_i <= 4'h1;
    cond_branch_i <= 1'b1;
    #1;
    chk({31'h0, pass_o}, 32'h0);
    cond_branch_i <= 1'b0;
    #1;
    chk({31'h0, pass_o}, 32'h1);
    // Fast interrupt entry banks registers 8 to 14
    exc_i <= '{CBRS_MODE_FIQ, 32'h0000001c, 4'h4};
    run_op(op_exc_entry, 32'h0);
    chk(st_o, 32'h400000d1);
    chk(sv_o, 32'h40000030);
    chk({31'h0, pass_o}, 32'h0);
    chk(rd_a_o, 32'h0);
    do_wr(4'h9, 32'h00000099);
    chk(rd_a_o, 32'h00000099);
    run_op(op_status_write, 32'h000000d5);
    chk(st_o, 32'h000000d1);
    run_op(op_saved_write, 32'h00000010);
    chk(sv_o, 32'h00000010);
    run_op(op_branch, 32'h00000303);
    chk(pc_o, 32'h00000300);
    run_op(op_exc_return, 32'h00000200);
    chk(st_o, 32'h00000010);
    chk(rd_a_o, 32'h00000066);
    $display("Test banking and flags done");
    test_done();
  end
endmodule
